// ---- core/sfw_current_write_pointer.sv ----
// Sector FIFO write pointer block with its read-only register window
`timescale 1ns/1ps
// Summary of operation
// - High register shows current pointer bits 13..8
// - Each word stored at current write pointer
// - Unconfirmed data stays hidden from read side
// - CRC error aborts written data, not confirmed
// - Abort reloads current pointer from committed copy
// - Empty flag in high register bit 7
// - Clear bit fully empties the FIFO
// - Register shows committed pointer low byte
// - Confirm copies current pointer into committed
// - Read side limited to committed pointer
// - Register shows current pointer low byte
module sfw_current_write_pointer #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    // Write side from the USB buffer manager
    input  wire logic              wr_valid_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              confirm_i,
    input  wire logic              crc_abort_i,
    // Clear bit from the interface access register
    input  wire logic              fifo_clear_i,
    // Read side
    input  wire sfw_pkg::sfw_ptr_t rd_ptr_i,
    output logic                   fifo_empty_o,
    output sfw_pkg::sfw_ptr_t      rd_limit_o,
    // Sector FIFO memory write port
    output logic                   mem_we_o,
    output sfw_pkg::sfw_ptr_t      mem_addr_o,
    output logic [DATA_W-1:0]      mem_wdata_o,
    // Microcontroller data space reads
    input  wire logic [15:0]       xaddr_i,
    input  wire logic              xrd_i,
    output logic [7:0]             xrdata_o,
    output logic                   xrvalid_o
);
    import sfw_pkg::*;

    sfw_ptr_if pif ();

    sfw_ptr_core u_core (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .pif       (pif)
    );

    logic              wr_take;
    logic              mem_we_ff;
    sfw_ptr_t          mem_addr_ff;
    logic [DATA_W-1:0] mem_wdata_ff;
    logic              nxt_mem_we;
    sfw_ptr_t          nxt_mem_addr;
    logic [DATA_W-1:0] nxt_mem_wdata;
    logic              empty_ff;
    logic              nxt_empty;
    logic [7:0]        rdata_ff;
    logic [7:0]        nxt_rdata;
    logic              rvalid_ff;
    logic              nxt_rvalid;

    // An aborting or clearing cycle stores nothing
    assign wr_take     = wr_valid_i && !crc_abort_i && !fifo_clear_i;
    assign pif.wr_en   = wr_take;
    assign pif.abort   = crc_abort_i;
    assign pif.confirm = confirm_i;
    assign pif.clear   = fifo_clear_i;

    // Memory write port, one cycle behind the request
    always_comb
    begin
        nxt_mem_we    = wr_take;
        nxt_mem_addr  = pif.cur_ptr;
        nxt_mem_wdata = wr_data_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            mem_we_ff    <= 1'b0;
            mem_addr_ff  <= PTR_RESET;
            mem_wdata_ff <= '0;
        end
        else
        begin
            mem_we_ff    <= nxt_mem_we;
            mem_addr_ff  <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
        end
    end

    // Empty looks only at committed data, so pending writes read as empty
    always_comb
    begin
        nxt_empty = (rd_ptr_i == pif.com_ptr);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            empty_ff <= EMPTY_RESET;
        end
        else
        begin
            empty_ff <= nxt_empty;
        end
    end

    // Register read decode; unmapped addresses read zero
    always_comb
    begin
        nxt_rdata  = rdata_ff;
        nxt_rvalid = xrd_i;
        if (xrd_i)
        begin
            nxt_rdata = REG_RESET;
            if (xaddr_i == ADDR_WP_LOW)
            begin
                nxt_rdata = pif.cur_ptr[7:0];
            end
            else if (xaddr_i == ADDR_WP_HIGH)
            begin
                nxt_rdata[HIGH_W-1:0] = pif.cur_ptr[PTR_W-1:HIGH_LSB];
                nxt_rdata[EMPTY_BIT]  = empty_ff;
            end
            else if (xaddr_i == ADDR_CP_LOW)
            begin
                nxt_rdata = pif.com_ptr[7:0];
            end
            else if (xaddr_i == ADDR_CP_HIGH)
            begin
                nxt_rdata[HIGH_W-1:0] = pif.com_ptr[PTR_W-1:HIGH_LSB];
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            rdata_ff  <= REG_RESET;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign fifo_empty_o = empty_ff;
    assign rd_limit_o   = pif.com_ptr;
    assign mem_we_o     = mem_we_ff;
    assign mem_addr_o   = mem_addr_ff;
    assign mem_wdata_o  = mem_wdata_ff;
    assign xrdata_o     = rdata_ff;
    assign xrvalid_o    = rvalid_ff;

    sequence abort_s;
        crc_abort_i && !fifo_clear_i;
    endsequence

    sequence plain_write_s;
        wr_take && !confirm_i;
    endsequence

    store_at_ptr_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        wr_take |=> mem_we_o && mem_addr_o == $past(pif.cur_ptr))
        else $error("Word not stored at current pointer");

    hidden_write_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        plain_write_s |=> $stable(rd_limit_o))
        else $error("Unconfirmed write became visible");

    abort_discard_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        abort_s |=> !mem_we_o && $stable(rd_limit_o))
        else $error("Aborted data was stored or confirmed");

    abort_rewind_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        abort_s |=> pif.cur_ptr == $past(pif.com_ptr))
        else $error("Abort did not rewind write pointer");

    high_reg_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        xrd_i && xaddr_i == ADDR_WP_HIGH |=> xrvalid_o
            && xrdata_o[HIGH_W-1:0] == $past(pif.cur_ptr[PTR_W-1:HIGH_LSB])
            && !xrdata_o[RESERVED_BIT])
        else $error("High register wrong");

    empty_bit_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        xrd_i && xaddr_i == ADDR_WP_HIGH |=>
            xrdata_o[EMPTY_BIT] == $past(fifo_empty_o))
        else $error("Empty bit not in high register");

    clear_all_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        fifo_clear_i |=> pif.cur_ptr == PTR_RESET && rd_limit_o == PTR_RESET)
        else $error("Clear did not empty the FIFO");

    com_low_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        xrd_i && xaddr_i == ADDR_CP_LOW |=> xrdata_o == $past(rd_limit_o[7:0]))
        else $error("Committed low register wrong");

    commit_copy_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        confirm_i && !crc_abort_i && !fifo_clear_i |=>
            rd_limit_o == pif.cur_ptr)
        else $error("Confirm did not copy pointer");

    limit_cause_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !$stable(rd_limit_o) |-> $past(confirm_i || fifo_clear_i))
        else $error("Read limit moved without confirm");

    cur_low_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        xrd_i && xaddr_i == ADDR_WP_LOW |=> xrdata_o == $past(pif.cur_ptr[7:0]))
        else $error("Write pointer low register wrong");

    ptr_step_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        wr_take ##1 wr_take |=>
            pif.cur_ptr == PTR_W'($past(pif.cur_ptr, 2) + 2))
        else $error("Write pointer did not step by one");

    empty_cmp_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        rd_ptr_i == rd_limit_o ##1 $stable(rd_limit_o) |-> fifo_empty_o)
        else $error("Empty flag not set on equal pointers");
endmodule

// ---- core/sfw_pkg.sv ----
// Constants and types shared by the sector FIFO write pointer files
package sfw_pkg;
    // Pointer geometry
    localparam int              PTR_W        = 14;
    localparam int              HIGH_LSB     = 8;
    localparam int              HIGH_W       = 6;
    localparam int              EMPTY_BIT    = 7;
    localparam int              RESERVED_BIT = 6;
    // Register byte addresses in the microcontroller data space
    localparam logic [15:0]     ADDR_WP_LOW  = 16'hf0eb;
    localparam logic [15:0]     ADDR_WP_HIGH = 16'hf0ec;
    localparam logic [15:0]     ADDR_CP_LOW  = 16'hf0ed;
    localparam logic [15:0]     ADDR_CP_HIGH = 16'hf0ee;
    // Reset values
    localparam logic [7:0]      REG_RESET    = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RESET   = 14'h0000;
    localparam logic [PTR_W-1:0] PTR_ONE     = 14'h0001;
    localparam logic            EMPTY_RESET  = 1'b0;

    typedef logic [PTR_W-1:0] sfw_ptr_t;
endpackage

// ---- core/sfw_ptr_core.sv ----
// Current and committed write pointers of the sector FIFO
`timescale 1ns/1ps
module sfw_ptr_core (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // Pointer control and state
    sfw_ptr_if.core   pif
);
    import sfw_pkg::*;

    sfw_ptr_t cur_ff;
    sfw_ptr_t com_ff;
    sfw_ptr_t nxt_cur;
    sfw_ptr_t nxt_com;

    // Clear beats abort, abort beats write and confirm
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_com = com_ff;
        if (pif.clear)
        begin
            nxt_cur = PTR_RESET;
            nxt_com = PTR_RESET;
        end
        else if (pif.abort)
        begin
            nxt_cur = com_ff;
        end
        else
        begin
            if (pif.wr_en)
            begin
                // Natural wrap from the top value back to zero
                nxt_cur = cur_ff + PTR_ONE;
            end
            if (pif.confirm)
            begin
                // A write in the confirming cycle is included
                nxt_com = nxt_cur;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cur_ff <= PTR_RESET;
            com_ff <= PTR_RESET;
        end
        else
        begin
            cur_ff <= nxt_cur;
            com_ff <= nxt_com;
        end
    end

    assign pif.cur_ptr = cur_ff;
    assign pif.com_ptr = com_ff;
endmodule

// ---- core/sfw_ptr_if.sv ----
// Carrier between the register front end and the pointer core
`timescale 1ns/1ps
interface sfw_ptr_if;
    import sfw_pkg::*;
    logic     wr_en;
    logic     abort;
    logic     confirm;
    logic     clear;
    sfw_ptr_t cur_ptr;
    sfw_ptr_t com_ptr;

    modport core (
        input  wr_en,
        input  abort,
        input  confirm,
        input  clear,
        output cur_ptr,
        output com_ptr
    );
    modport ctrl (
        output wr_en,
        output abort,
        output confirm,
        output clear,
        input  cur_ptr,
        input  com_ptr
    );
endinterface

// ---- sim/sfw_rd_model.sv ----
// Read-side partner: consumes committed entries one per cycle
`timescale 1ns/1ps
module sfw_rd_model (
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    input  wire logic              clear_i,
    input  wire logic              en_i,
    input  wire sfw_pkg::sfw_ptr_t limit_i,
    output sfw_pkg::sfw_ptr_t      rd_ptr_o
);
    import sfw_pkg::*;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || clear_i)
            rd_ptr_o <= PTR_RESET;
        else if (en_i && rd_ptr_o != limit_i)
            rd_ptr_o <= rd_ptr_o + PTR_ONE;
    end
endmodule

// ---- sim/test_sfw_current_write_pointer.sv ----
// Self-checking bench of the sector FIFO write pointer block
`timescale 1ns/1ps
module test_sfw_current_write_pointer;
    import sfw_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_valid, confirm, abort, clr, xrd, rd_en, empty, mwe, xrv;
    logic [7:0] wdata, mdata, xrdata;
    logic [15:0] xaddr;
    sfw_ptr_t rd_ptr, limit, maddr;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    sfw_current_write_pointer #(.DATA_W(8)) i_dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_valid_i(wr_valid),
        .wr_data_i(wdata), .confirm_i(confirm), .crc_abort_i(abort),
        .fifo_clear_i(clr), .rd_ptr_i(rd_ptr), .fifo_empty_o(empty),
        .rd_limit_o(limit), .mem_we_o(mwe), .mem_addr_o(maddr),
        .mem_wdata_o(mdata), .xaddr_i(xaddr), .xrd_i(xrd),
        .xrdata_o(xrdata), .xrvalid_o(xrv)
    );
    sfw_rd_model i_rd (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clear_i(clr),
        .en_i(rd_en), .limit_i(limit), .rd_ptr_o(rd_ptr)
    );

    initial
    begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Whole run is about 16.4k cycles; ceiling leaves ample margin
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        xrd = 1'b1;
        xaddr = a;
        @(negedge ref_clk_i);
        xrd = 1'b0;
        chk({15'h0000, xrv}, 16'h0001, "read valid");
        chk({8'h00, xrdata}, {8'h00, exp}, "read data");
    endtask

    // Holds the write strobe for n back-to-back words
    task automatic wr_n(input int n, input logic [15:0] first);
        for (int k = 0; k < n; k++)
        begin
            @(negedge ref_clk_i);
            wr_valid = 1'b1;
            wdata = 8'(k + 8'h5a);
            if (k > 0)
                chk({2'b00, maddr}, first + 16'(k - 1), "write addr");
        end
        @(negedge ref_clk_i);
        wr_valid = 1'b0;
        chk({15'h0000, mwe}, 16'h0001, "write strobe");
        chk({2'b00, maddr}, 16'((first + n - 1) & 16'h3fff), "last addr");
        chk({8'h00, mdata}, 16'(8'(n - 1 + 8'h5a)), "write data");
    endtask

    task automatic pulse(input int sel);
        @(negedge ref_clk_i);
        {clr, abort, confirm} = 3'(1 << sel);
        @(negedge ref_clk_i);
        {clr, abort, confirm} = 3'b000;
        @(negedge ref_clk_i);
    endtask

    task automatic t_reset();
        reg_rd(ADDR_WP_LOW, 8'h00);
        reg_rd(ADDR_WP_HIGH, 8'h80);
        reg_rd(ADDR_CP_LOW, 8'h00);
        reg_rd(16'h0000, 8'h00);
    endtask

    task automatic t_commit();
        reg_rd(ADDR_WP_HIGH, 8'h80);
        wr_n(3, 16'h0000);
        chk({2'b00, limit}, 16'h0000, "limit before confirm");
        chk({15'h0000, empty}, 16'h0001, "hidden data");
        pulse(0);
        chk({2'b00, limit}, 16'h0003, "limit after confirm");
        chk({15'h0000, empty}, 16'h0000, "not empty");
        reg_rd(ADDR_CP_LOW, 8'h03);
    endtask

    task automatic t_abort();
        wr_n(2, 16'h0003);
        reg_rd(ADDR_WP_LOW, 8'h05);
        @(negedge ref_clk_i);
        wr_valid = 1'b1;
        abort = 1'b1;
        @(negedge ref_clk_i);
        {wr_valid, abort} = 2'b00;
        chk({15'h0000, mwe}, 16'h0000, "write during abort");
        reg_rd(ADDR_WP_LOW, 8'h03);
        chk({2'b00, limit}, 16'h0003, "limit kept");
    endtask

    task automatic t_drain();
        int w;
        w = 0;
        rd_en = 1'b1;
        while (empty !== 1'b1 && w < 20)
        begin
            @(negedge ref_clk_i);
            w++;
        end
        rd_en = 1'b0;
        chk({15'h0000, 1'(w < 20)}, 16'h0001, "drain limit");
        chk({2'b00, rd_ptr}, 16'h0003, "read stops at limit");
        chk({15'h0000, empty}, 16'h0001, "empty after drain");
    endtask

    task automatic t_clear();
        wr_n(4, 16'h0003);
        pulse(0);
        chk({15'h0000, empty}, 16'h0000, "filled");
        pulse(2);
        chk({2'b00, limit}, 16'h0000, "limit cleared");
        chk({15'h0000, empty}, 16'h0001, "empty after clear");
        reg_rd(ADDR_WP_LOW, 8'h00);
        reg_rd(ADDR_WP_HIGH, 8'h80);
    endtask

    task automatic t_wrap();
        wr_n(16383, 16'h0000);
        reg_rd(ADDR_WP_LOW, 8'hff);
        reg_rd(ADDR_WP_HIGH, 8'hbf);
        pulse(0);
        reg_rd(ADDR_CP_HIGH, 8'h3f);
        reg_rd(ADDR_CP_LOW, 8'hff);
        wr_n(1, 16'h3fff);
        reg_rd(ADDR_WP_HIGH, 8'h00);
    endtask

    initial
    begin
        {wr_valid, confirm, abort, clr, xrd, rd_en} = 6'h00;
        wdata = 8'h00;
        xaddr = 16'h0000;
        repeat (3) @(negedge ref_clk_i);
        srst_i = 1'b0;
        t_reset();
        t_commit();
        t_abort();
        t_drain();
        t_clear();
        t_wrap();
        stop_test();
    end
endmodule
